// ### verilog/cpp_pkg.sv
package cpp_pkg;
  // program memory map
  localparam logic [21:0] BOOT_BASE   = 22'h000000;
  localparam logic [21:0] BLK0_BASE   = 22'h000800;
  localparam logic [21:0] BLK1_BASE   = 22'h002000;
  localparam logic [21:0] BLK2_BASE   = 22'h004000;
  localparam logic [21:0] BLK3_BASE   = 22'h006000;
  localparam logic [21:0] MEM_END     = 22'h008000;
  localparam logic [21:0] ID_BASE     = 22'h200000;
  localparam logic [21:0] ID_LAST     = 22'h200007;
  localparam logic [21:0] CFG_BASE    = 22'h300000;
  localparam logic [21:0] CFG_LAST    = 22'h30000F;
  localparam logic [21:0] DEVID_BASE  = 22'h3FFFFE;
  localparam logic [21:0] DEVID_LAST  = 22'h3FFFFF;
  // protection byte offsets
  localparam logic [21:0] CODE_READ_LOCK_LOW   = 22'h300008;
  localparam logic [21:0] CODE_READ_LOCK_HIGH  = 22'h300009;
  localparam logic [21:0] WRITE_LOCK_LOW       = 22'h30000A;
  localparam logic [21:0] WRITE_LOCK_HIGH      = 22'h30000B;
  localparam logic [21:0] TABLE_READ_LOCK_LOW  = 22'h30000C;
  localparam logic [21:0] TABLE_READ_LOCK_HIGH = 22'h30000D;
  // field positions
  localparam int BLK_LSB      = 0;
  localparam int BOOT_BIT_CP  = 6;
  localparam int EEP_EXT_BIT  = 7;
  localparam int BOOT_BIT_WR  = 6;
  localparam int CFG_WR_BIT   = 5;
  localparam int EEP_WR_BIT   = 7;
  localparam int BOOT_BIT_TR  = 6;
  localparam int NBLK         = 5;
  // erased value: all ones means unprotected
  localparam logic [4:0] ERASED_BLK = 5'h1F;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
endpackage

// ### verilog/cpp_protect.sv
module cpp_protect (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        enable_i,
  // cpu table access
  input  wire logic        tbl_valid_i,
  input  wire logic        tbl_write_i,
  input  wire logic [21:0] tbl_addr_i,
  input  wire logic [21:0] tbl_pc_i,
  input  wire logic [7:0]  tbl_wdata_i,
  input  wire logic [7:0]  tbl_mem_rdata_i,
  // cpu eeprom access
  input  wire logic        eep_cpu_valid_i,
  input  wire logic        eep_cpu_write_i,
  // programmer access
  input  wire logic        prg_valid_i,
  input  wire logic        prg_write_i,
  input  wire logic        prg_eeprom_i,
  input  wire logic [21:0] prg_addr_i,
  input  wire logic [7:0]  prg_wdata_i,
  input  wire logic        prg_chip_erase_i,
  input  wire logic        prg_block_erase_i,
  input  wire logic [2:0]  prg_block_sel_i,
  // results
  output logic             tbl_grant_o,
  output logic [7:0]       tbl_rdata_o,
  output logic             eep_cpu_grant_o,
  output logic             prg_grant_o,
  output logic [7:0]       prg_rdata_o,
  output logic [4:0]       block_external_lock_o,
  output logic [4:0]       block_table_write_lock_o,
  output logic [4:0]       block_external_table_read_lock_o,
  output logic             eeprom_external_lock_o,
  output logic             eeprom_write_lock_o,
  output logic             config_write_lock_o
);

  // index 0 is boot block, 1..4 are blocks 0..3
  typedef struct packed {
    logic [4:0] ext_lock;
    logic [4:0] wr_lock;
    logic [4:0] trd_lock;
    logic       eep_ext;
    logic       eep_wr;
    logic       cfg_wr;
    logic       tbl_grant;
    logic [7:0] tbl_rdata;
    logic       eep_grant;
    logic       prg_grant;
    logic [7:0] prg_rdata;
  } cpp_state_s;

  // power-up image is the erased part, with every block open
  cpp_state_s st = '{ext_lock: cpp_pkg::ERASED_BLK, wr_lock: cpp_pkg::ERASED_BLK,
                     trd_lock: cpp_pkg::ERASED_BLK, eep_ext: 1'b1, eep_wr: 1'b1,
                     cfg_wr: 1'b1, default: '0};
  cpp_state_s next_st;

  logic [4:0] tgt_hit;
  logic [4:0] pc_hit;
  logic [4:0] prg_hit;
  logic [21:0] base_of [0:5];

  assign base_of[0] = cpp_pkg::BOOT_BASE;
  assign base_of[1] = cpp_pkg::BLK0_BASE;
  assign base_of[2] = cpp_pkg::BLK1_BASE;
  assign base_of[3] = cpp_pkg::BLK2_BASE;
  assign base_of[4] = cpp_pkg::BLK3_BASE;
  assign base_of[5] = cpp_pkg::MEM_END;

  // half-open ranges, so neighbouring blocks can never both claim an address
  genvar gi;
  generate
    for (gi = 0; gi < cpp_pkg::NBLK; gi++) begin : g_dec
      assign tgt_hit[gi] = (tbl_addr_i >= base_of[gi]) && (tbl_addr_i < base_of[gi+1]);
      assign pc_hit[gi]  = (tbl_pc_i   >= base_of[gi]) && (tbl_pc_i   < base_of[gi+1]);
      assign prg_hit[gi] = (prg_addr_i >= base_of[gi]) && (prg_addr_i < base_of[gi+1]);
    end
  endgenerate

  logic tgt_id;
  logic tgt_cfg;
  logic tgt_devid;
  logic prg_id;
  logic prg_cfg;
  assign tgt_id    = (tbl_addr_i >= cpp_pkg::ID_BASE) && (tbl_addr_i <= cpp_pkg::ID_LAST);
  assign tgt_cfg   = (tbl_addr_i >= cpp_pkg::CFG_BASE) && (tbl_addr_i <= cpp_pkg::CFG_LAST);
  assign tgt_devid = (tbl_addr_i >= cpp_pkg::DEVID_BASE) && (tbl_addr_i <= cpp_pkg::DEVID_LAST);
  assign prg_id    = (prg_addr_i >= cpp_pkg::ID_BASE) && (prg_addr_i <= cpp_pkg::ID_LAST);
  assign prg_cfg   = (prg_addr_i >= cpp_pkg::CFG_BASE) && (prg_addr_i <= cpp_pkg::CFG_LAST);

  // protection byte images, unimplemented bits read zero
  function automatic logic [7:0] lock_byte(input logic [21:0] a, input cpp_state_s s);
    logic [7:0] b;
    b = cpp_pkg::ZERO_BYTE;
    case (a)
      cpp_pkg::CODE_READ_LOCK_LOW: b[3:0] = s.ext_lock[4:1];
      cpp_pkg::CODE_READ_LOCK_HIGH: begin
        b[cpp_pkg::EEP_EXT_BIT] = s.eep_ext;
        b[cpp_pkg::BOOT_BIT_CP] = s.ext_lock[0];
      end
      cpp_pkg::WRITE_LOCK_LOW: b[3:0] = s.wr_lock[4:1];
      cpp_pkg::WRITE_LOCK_HIGH: begin
        b[cpp_pkg::EEP_WR_BIT]  = s.eep_wr;
        b[cpp_pkg::BOOT_BIT_WR] = s.wr_lock[0];
        b[cpp_pkg::CFG_WR_BIT]  = s.cfg_wr;
      end
      cpp_pkg::TABLE_READ_LOCK_LOW: b[3:0] = s.trd_lock[4:1];
      cpp_pkg::TABLE_READ_LOCK_HIGH: b[cpp_pkg::BOOT_BIT_TR] = s.trd_lock[0];
      default: b = cpp_pkg::ZERO_BYTE;
    endcase
    return b;
  endfunction

  logic       tbl_mem;
  logic       tbl_ok;
  logic       prg_mem;
  logic       prg_ok;
  logic [7:0] wbyte;
  logic [21:0] waddr;
  logic       wen;
  logic       prg_src;

  always_comb begin
    next_st = st;
    wen     = 1'b0;
    waddr   = prg_addr_i;
    wbyte   = prg_wdata_i;
    prg_src = 1'b0;
    tbl_mem = |tgt_hit;
    prg_mem = |prg_hit;
    // cpu table access
    if (tbl_write_i) begin
      tbl_ok = (tbl_mem && |(tgt_hit & st.wr_lock))
               || tgt_id
               || (tgt_cfg && st.cfg_wr);
    end else begin
      tbl_ok = (tbl_mem && |(tgt_hit & (st.trd_lock | pc_hit)))
               || tgt_id || tgt_cfg || tgt_devid;
    end
    // programmer access: external lock only here
    if (prg_eeprom_i) begin
      prg_ok = st.eep_ext && (!prg_write_i || st.eep_wr);
    end else if (prg_write_i) begin
      prg_ok = (prg_mem && |(prg_hit & st.ext_lock & st.wr_lock)) || prg_id || prg_cfg;
    end else begin
      prg_ok = (prg_mem && |(prg_hit & st.ext_lock)) || prg_id || prg_cfg;
    end
    next_st.tbl_grant = 1'b0;
    next_st.prg_grant = 1'b0;
    next_st.eep_grant = 1'b0;
    next_st.tbl_rdata = cpp_pkg::ZERO_BYTE;
    next_st.prg_rdata = cpp_pkg::ZERO_BYTE;
    if (tbl_valid_i) begin
      next_st.tbl_grant = tbl_ok;
      if (!tbl_write_i && tbl_ok) begin
        next_st.tbl_rdata = tgt_cfg ? lock_byte(tbl_addr_i, st) : tbl_mem_rdata_i;
      end
      if (tbl_write_i && tbl_ok && tgt_cfg) begin
        wen   = 1'b1;
        waddr = tbl_addr_i;
        wbyte = tbl_wdata_i;
      end
    end
    if (eep_cpu_valid_i) begin
      next_st.eep_grant = !eep_cpu_write_i || st.eep_wr;
    end
    if (prg_valid_i) begin
      next_st.prg_grant = prg_ok;
      if (!prg_write_i && prg_ok) begin
        next_st.prg_rdata = prg_cfg ? lock_byte(prg_addr_i, st) : tbl_mem_rdata_i;
      end
      if (prg_write_i && prg_ok && prg_cfg && !prg_eeprom_i) begin
        wen     = 1'b1;
        prg_src = 1'b1;
      end
    end
    // bits only clear: and new value into old
    if (wen) begin
      case (waddr)
        cpp_pkg::CODE_READ_LOCK_LOW:  next_st.ext_lock[4:1] = st.ext_lock[4:1] & wbyte[3:0];
        cpp_pkg::CODE_READ_LOCK_HIGH: begin
          next_st.eep_ext     = st.eep_ext & wbyte[cpp_pkg::EEP_EXT_BIT];
          next_st.ext_lock[0] = st.ext_lock[0] & wbyte[cpp_pkg::BOOT_BIT_CP];
        end
        cpp_pkg::WRITE_LOCK_LOW:      next_st.wr_lock[4:1] = st.wr_lock[4:1] & wbyte[3:0];
        cpp_pkg::WRITE_LOCK_HIGH: begin
          next_st.eep_wr     = st.eep_wr & wbyte[cpp_pkg::EEP_WR_BIT];
          next_st.wr_lock[0] = st.wr_lock[0] & wbyte[cpp_pkg::BOOT_BIT_WR];
          if (prg_src) begin
            next_st.cfg_wr = st.cfg_wr & wbyte[cpp_pkg::CFG_WR_BIT];
          end
        end
        cpp_pkg::TABLE_READ_LOCK_LOW:  next_st.trd_lock[4:1] = st.trd_lock[4:1] & wbyte[3:0];
        cpp_pkg::TABLE_READ_LOCK_HIGH: next_st.trd_lock[0] = st.trd_lock[0] & wbyte[cpp_pkg::BOOT_BIT_TR];
        default: next_st.ext_lock = next_st.ext_lock;
      endcase
    end
    // erase only from the programmer port; erase wins over a same-cycle clear
    if (prg_chip_erase_i) begin
      next_st.ext_lock = cpp_pkg::ERASED_BLK;
      next_st.wr_lock  = cpp_pkg::ERASED_BLK;
      next_st.trd_lock = cpp_pkg::ERASED_BLK;
      next_st.eep_ext  = 1'b1;
      next_st.eep_wr   = 1'b1;
      next_st.cfg_wr   = 1'b1;
    end else if (prg_block_erase_i && prg_block_sel_i < 3'(cpp_pkg::NBLK)) begin
      next_st.ext_lock[prg_block_sel_i] = 1'b1;
      next_st.wr_lock[prg_block_sel_i]  = 1'b1;
      next_st.trd_lock[prg_block_sel_i] = 1'b1;
    end
  end

  // reset leaves protection intact: only erase sets bits back
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st.tbl_grant <= 1'b0;
      st.tbl_rdata <= cpp_pkg::ZERO_BYTE;
      st.eep_grant <= 1'b0;
      st.prg_grant <= 1'b0;
      st.prg_rdata <= cpp_pkg::ZERO_BYTE;
    end else if (enable_i) begin
      st <= next_st;
    end
  end

  assign tbl_grant_o                      = st.tbl_grant;
  assign tbl_rdata_o                      = st.tbl_rdata;
  assign eep_cpu_grant_o                  = st.eep_grant;
  assign prg_grant_o                      = st.prg_grant;
  assign prg_rdata_o                      = st.prg_rdata;
  assign block_external_lock_o            = st.ext_lock;
  assign block_table_write_lock_o         = st.wr_lock;
  assign block_external_table_read_lock_o = st.trd_lock;
  assign eeprom_external_lock_o           = st.eep_ext;
  assign eeprom_write_lock_o              = st.eep_wr;
  assign config_write_lock_o              = st.cfg_wr;

  sequence s_tbl_locked_out;
    tbl_valid_i && !tbl_write_i && enable_i && tbl_mem && !(|(tgt_hit & (st.trd_lock | pc_hit)));
  endsequence

  AST_EXT_READ_ZERO: assert property (@(posedge clock_i) disable iff (reset_i)
    s_tbl_locked_out |=> (tbl_rdata_o == cpp_pkg::ZERO_BYTE) && !tbl_grant_o)
    else $error("locked table read returned data");
  AST_INSIDE_READ: assert property (@(posedge clock_i) disable iff (reset_i)
    (tbl_valid_i && !tbl_write_i && enable_i && |(tgt_hit & pc_hit)) |=> tbl_grant_o)
    else $error("same-block table read refused");
  AST_WRITE_LOCK: assert property (@(posedge clock_i) disable iff (reset_i)
    (tbl_valid_i && tbl_write_i && enable_i && |(tgt_hit & ~st.wr_lock)) |=> !tbl_grant_o)
    else $error("table write into locked block granted");
  AST_ONLY_CLEAR: assert property (@(posedge clock_i) disable iff (reset_i)
    (!prg_chip_erase_i && !prg_block_erase_i && enable_i) |=> ((st.wr_lock & ~$past(st.wr_lock)) == 5'h00))
    else $error("protection bit set without erase");
  AST_ERASE_ONES: assert property (@(posedge clock_i) disable iff (reset_i)
    (prg_chip_erase_i && enable_i) |=> (&st.ext_lock && &st.trd_lock && st.cfg_wr))
    else $error("erase left a bit cleared");
  AST_CFG_CPU: assert property (@(posedge clock_i) disable iff (reset_i)
    (!prg_valid_i && !prg_chip_erase_i) |=> (st.cfg_wr == $past(st.cfg_wr)))
    else $error("config lock changed without programmer");
  AST_EEP_EXT: assert property (@(posedge clock_i) disable iff (reset_i)
    (prg_valid_i && prg_eeprom_i && !st.eep_ext && enable_i) |=> !prg_grant_o)
    else $error("locked eeprom open to programmer");
  AST_EEP_CPU_READ: assert property (@(posedge clock_i) disable iff (reset_i)
    (eep_cpu_valid_i && !eep_cpu_write_i && enable_i) |=> eep_cpu_grant_o)
    else $error("cpu eeprom read refused");
  AST_ID_READ: assert property (@(posedge clock_i) disable iff (reset_i)
    (tbl_valid_i && !tbl_write_i && tgt_id && enable_i) |=> tbl_grant_o)
    else $error("id read refused");
  AST_UNIMPL: assert property (@(posedge clock_i) disable iff (reset_i)
    (tbl_valid_i && enable_i && tbl_addr_i >= cpp_pkg::MEM_END && tbl_addr_i < cpp_pkg::ID_BASE)
    |=> (!tbl_grant_o && tbl_rdata_o == cpp_pkg::ZERO_BYTE))
    else $error("unimplemented space answered");

  // requests that meet a lock, named so the checks below read plainly
  sequence s_eep_cpu_write;
    eep_cpu_valid_i && eep_cpu_write_i && enable_i;
  endsequence

  sequence s_eep_prg_write;
    prg_valid_i && prg_eeprom_i && prg_write_i && enable_i;
  endsequence

  sequence s_cfg_tbl_write;
    tbl_valid_i && tbl_write_i && tgt_cfg && enable_i;
  endsequence

  sequence s_prg_mem_read;
    prg_valid_i && !prg_eeprom_i && !prg_write_i && prg_mem && enable_i;
  endsequence

  AST_EEP_CPU_WRITE: assert property (@(posedge clock_i) disable iff (reset_i)
    (s_eep_cpu_write ##0 !st.eep_wr) |=> !eep_cpu_grant_o)
    else $error("cpu eeprom write passed the write lock");
  AST_EEP_PRG_WRITE: assert property (@(posedge clock_i) disable iff (reset_i)
    (s_eep_prg_write ##0 !st.eep_wr) |=> !prg_grant_o)
    else $error("programmer eeprom write passed the write lock");
  AST_CFG_LOCKED: assert property (@(posedge clock_i) disable iff (reset_i)
    (s_cfg_tbl_write ##0 !st.cfg_wr) |=> !tbl_grant_o)
    else $error("config write granted while locked");
  AST_PRG_EXT_LOCK: assert property (@(posedge clock_i) disable iff (reset_i)
    (s_prg_mem_read ##0 !(|(prg_hit & st.ext_lock)))
    |=> (!prg_grant_o && prg_rdata_o == cpp_pkg::ZERO_BYTE))
    else $error("locked block read by programmer");
  // erase is the only way back to one, so any rising lock bit is a leak
  AST_BLOCK_ERASE: assert property (@(posedge clock_i) disable iff (reset_i)
    (prg_block_erase_i && !prg_chip_erase_i && enable_i && prg_block_sel_i < 3'(cpp_pkg::NBLK))
    |=> (st.ext_lock[$past(prg_block_sel_i)] && st.wr_lock[$past(prg_block_sel_i)]
         && st.trd_lock[$past(prg_block_sel_i)]))
    else $error("block erase left a bit cleared");
  AST_ONLY_CLEAR_RD: assert property (@(posedge clock_i) disable iff (reset_i)
    (!prg_chip_erase_i && !prg_block_erase_i && enable_i)
    |=> (((st.ext_lock & ~$past(st.ext_lock)) | (st.trd_lock & ~$past(st.trd_lock))) == 5'h00))
    else $error("lock bit set without erase");
  AST_DEVID_WRITE: assert property (@(posedge clock_i) disable iff (reset_i)
    (tbl_valid_i && tbl_write_i && tgt_devid && enable_i) |=> !tbl_grant_o)
    else $error("device id write granted");
  AST_ID_WRITE: assert property (@(posedge clock_i) disable iff (reset_i)
    (tbl_valid_i && tbl_write_i && tgt_id && enable_i) |=> tbl_grant_o)
    else $error("id write refused");
  AST_TBL_CFG_READ: assert property (@(posedge clock_i) disable iff (reset_i)
    (tbl_valid_i && !tbl_write_i && tgt_cfg && enable_i) |=> tbl_grant_o)
    else $error("config read refused");

endmodule

// ### verif/cpp_mem_model.sv
module cpp_mem_model (
  input  wire logic [21:0] addr_i,
  output logic      [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // array contents differ byte to byte; a byte reads zero only where addr_i[7:0] ^ addr_i[15:8] is 5A
  assign rdata_o = addr_i[7:0] ^ addr_i[15:8] ^ 8'h5A;
endmodule

// ### verif/cpp_protect_test.sv
module cpp_protect_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 0, reset_i = 1, enable_i = 1, en = 1;
  logic        tbl_valid_i = 0, tbl_write_i = 0, eep_cpu_valid_i = 0, eep_cpu_write_i = 0;
  logic        prg_valid_i = 0, prg_write_i = 0, prg_eeprom_i = 0;
  logic        prg_chip_erase_i = 0, prg_block_erase_i = 0;
  logic [2:0]  prg_block_sel_i = 3'h0;
  logic [21:0] tbl_addr_i = 22'h0, tbl_pc_i = 22'h0, prg_addr_i = 22'h0, ra, rp;
  logic [7:0]  tbl_wdata_i = 8'h0, prg_wdata_i = 8'h0, tbl_mem_rdata_i, tbl_rdata_o, prg_rdata_o;
  logic        tbl_grant_o, eep_cpu_grant_o, prg_grant_o;
  logic        eeprom_external_lock_o, eeprom_write_lock_o, config_write_lock_o;
  logic [4:0]  block_external_lock_o, block_table_write_lock_o, block_external_table_read_lock_o;
  int          n_fail = 0, cmp_count = 0, seed = 39382;
  int          ext[5], wrl[5], trd[5], eext, ewr, cwr;
  always #5 clock_i = ~clock_i;
  cpp_mem_model u_cpp_mem_model (
    .addr_i (tbl_valid_i ? tbl_addr_i : prg_addr_i),
    .rdata_o(tbl_mem_rdata_i)
  );
  cpp_protect u_cpp_protect (
    .clock_i, .reset_i, .enable_i, .tbl_valid_i, .tbl_write_i, .tbl_addr_i, .tbl_pc_i,
    .tbl_wdata_i, .tbl_mem_rdata_i, .eep_cpu_valid_i, .eep_cpu_write_i, .prg_valid_i,
    .prg_write_i, .prg_eeprom_i, .prg_addr_i, .prg_wdata_i, .prg_chip_erase_i,
    .prg_block_erase_i, .prg_block_sel_i, .tbl_grant_o, .tbl_rdata_o, .eep_cpu_grant_o,
    .prg_grant_o, .prg_rdata_o, .block_external_lock_o, .block_table_write_lock_o,
    .block_external_table_read_lock_o, .eeprom_external_lock_o, .eeprom_write_lock_o,
    .config_write_lock_o
  );
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_grant(string n, int e, logic g);
    cmp(n, 8'(e), 8'(g));
  endtask
  task automatic cmp_data(string n, logic [7:0] e, logic [7:0] g);
    cmp(n, e, g);
  endtask
  task automatic cmp_lock(string n, int e, logic g);
    cmp(n, 8'(e), 8'(g));
  endtask
  // protection byte images as a table read or the programmer should see them
  function automatic logic [7:0] img(logic [21:0] a);
    case (a)
      22'h300008: return 8'({ext[4][0], ext[3][0], ext[2][0], ext[1][0]});
      22'h300009: return {eext[0], ext[0][0], 6'h00};
      22'h30000A: return 8'({wrl[4][0], wrl[3][0], wrl[2][0], wrl[1][0]});
      22'h30000B: return {ewr[0], wrl[0][0], cwr[0], 5'h00};
      22'h30000C: return 8'({trd[4][0], trd[3][0], trd[2][0], trd[1][0]});
      22'h30000D: return {1'b0, trd[0][0], 6'h00};
      default: return 8'h00;
    endcase
  endfunction
  function automatic int blk(logic [21:0] a);
    if (a < 22'h000800) return 0;
    if (a < 22'h002000) return 1;
    return (a < 22'h008000) ? 32'(a[14:13]) + 1 : 9;
  endfunction
  // kinds: 0 table access, 1 programmer memory, 2 programmer eeprom, 3 cpu eeprom
  function automatic int allow(int k, logic w, logic [21:0] a, logic [21:0] pc);
    int b;
    b = blk(a);
    if (k == 3) return w ? ewr : 1;
    if (k == 2) return w ? eext & ewr : eext;
    if (a >= 22'h200000 && a <= 22'h200007) return 1;
    if (a >= 22'h300000 && a <= 22'h30000F) return (k == 0 && w) ? cwr : 1;
    if (a >= 22'h3FFFFE) return !w;
    if (b == 9) return 0;
    if (k == 1) return w ? ext[b] & wrl[b] : ext[b];
    return w ? wrl[b] : (trd[b] | int'(blk(pc) == b));
  endfunction
  task automatic apply(logic [21:0] a, logic [7:0] d, logic prg);
    for (int i = 1; i < 5; i++) begin
      if (a == 22'h300008) ext[i] &= d[i-1];
      if (a == 22'h30000A) wrl[i] &= d[i-1];
      if (a == 22'h30000C) trd[i] &= d[i-1];
    end
    if (a == 22'h300009) begin
      eext &= d[7];
      ext[0] &= d[6];
    end
    if (a == 22'h30000B) begin
      ewr &= d[7];
      wrl[0] &= d[6];
      if (prg) cwr &= d[5];
    end
    if (a == 22'h30000D) trd[0] &= d[6];
  endtask
  task automatic locks();
    for (int i = 0; i < 5; i++) begin
      cmp_lock("external_lock", ext[i], block_external_lock_o[i]);
      cmp_lock("table_write_lock", wrl[i], block_table_write_lock_o[i]);
      cmp_lock("table_read_lock", trd[i], block_external_table_read_lock_o[i]);
    end
    cmp_lock("eeprom_external_lock", eext, eeprom_external_lock_o);
    cmp_lock("eeprom_write_lock", ewr, eeprom_write_lock_o);
    cmp_lock("config_write_lock", cwr, config_write_lock_o);
  endtask
  task automatic op(int k, logic w, logic [21:0] a, logic [21:0] pc, logic [7:0] d);
    int ok;
    logic [7:0] m;
    ok = en ? allow(k, w, a, pc) : 0;
    m = (a >= 22'h300000 && a <= 22'h30000F) ? img(a) : a[7:0] ^ a[15:8] ^ 8'h5A;
    if (ok == 0 || w) m = 8'h00;
    @(posedge clock_i);
    enable_i <= en;
    tbl_valid_i <= (k == 0);
    prg_valid_i <= (k == 1 || k == 2);
    prg_eeprom_i <= (k == 2);
    eep_cpu_valid_i <= (k == 3);
    {tbl_write_i, prg_write_i, eep_cpu_write_i} <= {3{w}};
    {tbl_addr_i, prg_addr_i, tbl_pc_i} <= {a, a, pc};
    {tbl_wdata_i, prg_wdata_i} <= {d, d};
    @(posedge clock_i);
    {tbl_valid_i, prg_valid_i, eep_cpu_valid_i} <= 3'h0;
    #1;
    if (ok != 0 && w && k < 2) apply(a, d, k == 1);
    if (k == 0) cmp_grant("tbl_grant", ok, tbl_grant_o);
    if (k == 0) cmp_data("tbl_rdata", m, tbl_rdata_o);
    if (k == 1) cmp_data("prg_rdata", m, prg_rdata_o);
    if (k == 1 || k == 2) cmp_grant("prg_grant", ok, prg_grant_o);
    if (k == 3) cmp_grant("eep_cpu_grant", ok, eep_cpu_grant_o);
  endtask
  task automatic erase(logic chip, int sel);
    @(posedge clock_i);
    enable_i <= en;
    prg_chip_erase_i <= chip;
    prg_block_erase_i <= !chip;
    prg_block_sel_i <= 3'(sel);
    @(posedge clock_i);
    {prg_chip_erase_i, prg_block_erase_i} <= 2'h0;
    #1;
    for (int i = 0; i < 5; i++) begin
      if (chip || i == sel) {ext[i], wrl[i], trd[i]} = {32'h1, 32'h1, 32'h1};
    end
    if (chip) {eext, ewr, cwr} = {32'h1, 32'h1, 32'h1};
    locks();
  endtask
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    for (int i = 0; i < 5; i++) {ext[i], wrl[i], trd[i]} = {32'h1, 32'h1, 32'h1};
    {eext, ewr, cwr} = {32'h1, 32'h1, 32'h1};
    repeat (5) @(posedge clock_i);
    reset_i <= 0;
    #1;
    locks();
    op(0, 1, 22'h30000C, 0, 8'hFD);
    op(0, 0, 22'h003FFF, 22'h002000, 0);
    op(0, 0, 22'h002100, 22'h001FFF, 0);
    op(0, 1, 22'h30000C, 0, 8'hFF);
    op(0, 1, 22'h30000A, 0, 8'hFE);
    op(0, 1, 22'h001FFF, 0, 8'h11);
    op(0, 1, 22'h002000, 0, 8'h22);
    // block 3 bit left at one, as on the smaller part
    op(0, 1, 22'h300008, 0, 8'hFB);
    op(0, 0, 22'h300008, 0, 0);
    op(1, 0, 22'h004000, 0, 0);
    op(0, 0, 22'h004000, 22'h000000, 0);
    op(1, 0, 22'h000100, 0, 0);
    op(0, 0, 22'h008000, 0, 0);
    op(1, 1, 22'h009000, 0, 8'h33);
    op(0, 0, 22'h200003, 22'h002000, 0);
    op(0, 1, 22'h200007, 0, 8'h44);
    op(1, 0, 22'h200000, 0, 0);
    op(0, 0, 22'h3FFFFE, 0, 0);
    op(0, 1, 22'h3FFFFF, 0, 8'h66);
    locks();
    erase(0, 2);
    op(0, 0, 22'h002100, 22'h000100, 0);
    op(0, 1, 22'h30000D, 0, 8'hBF);
    op(0, 0, 22'h0007FF, 22'h000800, 0);
    op(0, 0, 22'h000400, 22'h000000, 0);
    repeat (24) begin
      ra = 22'($random(seed)) & 22'h007FFF;
      rp = 22'($random(seed)) & 22'h007FFF;
      op(0, 1'($random(seed)), ra, rp, 8'($random(seed)));
    end
    op(3, 1, 0, 0, 0);
    op(0, 1, 22'h30000B, 0, 8'h5F);
    op(3, 1, 0, 0, 0);
    op(3, 0, 0, 0, 0);
    op(2, 1, 0, 0, 0);
    op(2, 0, 0, 0, 0);
    op(0, 1, 22'h300009, 0, 8'h7F);
    op(2, 0, 0, 0, 0);
    op(1, 1, 22'h30000B, 0, 8'hDF);
    op(0, 1, 22'h300000, 0, 8'h00);
    op(0, 0, 22'h30000B, 0, 0);
    op(1, 0, 22'h300009, 0, 0);
    locks();
    en = 0;
    op(0, 0, 22'h200000, 0, 0);
    en = 1;
    erase(1, 0);
    results();
  end
endmodule
